//--- pkg/wt_pkg.sv
// Constants and types shared by the watch timer block
package wt_pkg;
   // Bus address width in bits
   localparam int ADDR_W = 12;
   // Register indices; byte address is four times the index
   localparam logic [9:0] IDX_MODE = 10'h09d;
   localparam logic [9:0] IDX_COUNT = 10'h09e;
   localparam logic [9:0] IDX_STATUS = 10'h09f;
   localparam logic [9:0] IDX_MASK = 10'h0a0;
   // Field positions
   localparam int MODE_RUN_BIT = 7;
   localparam int MODE_FLAG_BIT = 4;
   localparam int CLEAR_BIT = 7;
   // Counter geometry
   localparam int PRE_W = 14;
   localparam int UPPER_W = 7;
   localparam int MAIN_DIV_W = 8;
   // Prescaler low-bit spans for the fixed intervals
   localparam int SPAN_2048 = 11;
   localparam int SPAN_8192 = 13;
   // Values after reset
   localparam logic [6:0] RELOAD_RESET = 7'h7f;
   localparam logic MASK_RESET = 1'h0;
   // Bus answers
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Watch clock sources
   typedef enum logic [1:0] {SRC_SUB, SRC_DIV256, SRC_DIV128, SRC_DIV64} source_t;
   // Interrupt intervals
   typedef enum logic [1:0] {INT_2048, INT_8192, INT_16384, INT_RELOAD} interval_t;
   // Mode register contents
   typedef struct packed {
      logic run_en;
      logic irq_flag;
      interval_t interval_select;
      source_t source_select;
   } mode_t;
   localparam mode_t MODE_RESET = '{1'b0, 1'b0, INT_2048, SRC_SUB};
endpackage

//--- src/watch_timer_rtc.sv
// Watch timer real-time clock with AXI4-Lite register access
// What this block does
// - Clearing run enable stops and zeroes counter
// - Sub clock keeps counting during CPU stop
// - 21-bit counter: 14-bit prescaler, 7-bit upper
// - Upper section reloads; period 2^14 times (value+1)
// - Shared write loads reload, bit7 clears
// - Shared read returns upper count, bit7 zero
// - Source select: sub, main/256, /128, /64
// - Interval select: 2048, 8192, 16384, reload
// - Mode register bit layout, bits 6:5 unused
// - Interrupt condition sets flag, raises request
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none
module watch_timer_rtc
   import wt_pkg::*;
(
   input wire logic aclk, // 100 MHz clock
   input wire logic aresetn, // Synchronous reset, low
   input wire logic sub_tick, // Sub oscillator enable pulse
   input wire logic main_osc_clock, // Main oscillator enable pulse
   input wire logic cpu_stop, // CPU stop mode, main halted
   input wire logic irq_ack, // Interrupt controller acknowledge
   output logic watch_irq_flag, // Interrupt request flag
   output logic irq, // Masked status interrupt
   input wire logic awvalid, // Write address valid
   output logic awready, // Write address ready
   input wire logic [ADDR_W-1:0] awaddr, // Write address
   input wire logic wvalid, // Write data valid
   output logic wready, // Write data ready
   input wire logic [31:0] wdata, // Write data
   input wire logic [3:0] wstrb, // Write byte strobes
   output logic bvalid, // Write response valid
   input wire logic bready, // Write response ready
   output logic [1:0] bresp, // Write response
   input wire logic arvalid, // Read address valid
   output logic arready, // Read address ready
   input wire logic [ADDR_W-1:0] araddr, // Read address
   output logic rvalid, // Read data valid
   input wire logic rready, // Read data ready
   output logic [31:0] rdata, // Read data
   output logic [1:0] rresp // Read response
);

   // All state of the block
   typedef struct packed {
      logic awready;
      logic wready;
      logic aw_have;
      logic [ADDR_W-1:0] aw_addr;
      logic w_have;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      mode_t mode;
      logic [UPPER_W-1:0] reload;
      logic clr_strobe;
      logic [MAIN_DIV_W-1:0] main_div;
      logic [PRE_W-1:0] pre;
      logic [UPPER_W-1:0] upper;
      logic status;
      logic mask;
      logic irq;
   } state_t;

   state_t st; // Registered state
   state_t nx; // Next state
   logic main_en; // Divided main clock pulse
   logic tick; // Watch clock pulse
   logic evt; // Interrupt condition
   logic do_write; // Write executes this cycle
   logic [9:0] w_idx; // Write register index
   logic flag_clr; // Software clears mode flag
   logic stat_clr; // Software clears status bit

   // Divided main clock hit for the selected ratio
   function automatic logic div_hit(input logic [MAIN_DIV_W-1:0] d, input source_t s);
      unique case (s)
         SRC_DIV256: div_hit = &d;
         SRC_DIV128: div_hit = &d[6:0];
         SRC_DIV64: div_hit = &d[5:0];
         SRC_SUB: div_hit = 1'b0;
      endcase
   endfunction

   // Interrupt condition for the selected interval
   function automatic logic ival_hit(input logic [PRE_W-1:0] p, input logic [UPPER_W-1:0] u,
                                     input logic [UPPER_W-1:0] r, input interval_t i);
      unique case (i)
         INT_2048: ival_hit = &p[SPAN_2048-1:0];
         INT_8192: ival_hit = &p[SPAN_8192-1:0];
         INT_16384: ival_hit = &p;
         INT_RELOAD: ival_hit = (&p) && (u >= r);
      endcase
   endfunction

   // Register read mux
   function automatic logic [31:0] read_word(input logic [9:0] idx, input state_t s);
      unique case (idx)
         IDX_MODE: read_word = {24'h00_0000, s.mode.run_en, 2'b00, s.mode.irq_flag,
                                s.mode.interval_select, s.mode.source_select};
         IDX_COUNT: read_word = {25'h000_0000, s.upper};
         IDX_STATUS: read_word = {31'h0000_0000, s.status};
         IDX_MASK: read_word = {31'h0000_0000, s.mask};
         default: read_word = 32'h0000_0000;
      endcase
   endfunction

   // Mapped register index check
   function automatic logic mapped(input logic [9:0] idx);
      mapped = (idx == IDX_MODE) || (idx == IDX_COUNT) || (idx == IDX_STATUS) || (idx == IDX_MASK);
   endfunction

   // Next-state logic
   always_comb
   begin
      nx = st;
      nx.clr_strobe = 1'b0;
      flag_clr = 1'b0;
      stat_clr = 1'b0;
      evt = 1'b0;
      w_idx = st.aw_addr[ADDR_W-1:2];
      do_write = st.aw_have && st.w_have && !st.bvalid;
      // Main divider runs only while the CPU is awake
      if (main_osc_clock && !cpu_stop)
      begin
         nx.main_div = st.main_div + 1'b1;
      end
      main_en = main_osc_clock && !cpu_stop && div_hit(st.main_div, st.mode.source_select);
      tick = (st.mode.source_select == SRC_SUB) ? sub_tick : main_en;
      if (!st.mode.run_en || st.clr_strobe)
      begin
         nx.pre = '0;
         nx.upper = '0;
      end
      else if (tick)
      begin
         nx.pre = st.pre + 1'b1;
         if (&st.pre)
         begin
            nx.upper = (st.upper >= st.reload) ? '0 : st.upper + 1'b1;
         end
         evt = ival_hit(st.pre, st.upper, st.reload, st.mode.interval_select);
      end
      // Address and data capture
      if (st.awready && awvalid)
      begin
         nx.aw_have = 1'b1;
         nx.aw_addr = awaddr;
      end
      if (st.wready && wvalid)
      begin
         nx.w_have = 1'b1;
         nx.w_data = wdata;
         nx.w_strb = wstrb;
      end
      if (st.bvalid && bready)
      begin
         nx.bvalid = 1'b0;
      end
      // Write execution once both halves are held
      if (do_write)
      begin
         nx.aw_have = 1'b0;
         nx.w_have = 1'b0;
         nx.bvalid = 1'b1;
         nx.bresp = mapped(w_idx) ? RESP_OKAY : RESP_SLVERR;
         if (st.w_strb[0])
         begin
            unique case (w_idx)
               IDX_MODE:
               begin
                  nx.mode.run_en = st.w_data[MODE_RUN_BIT];
                  nx.mode.interval_select = interval_t'(st.w_data[3:2]);
                  nx.mode.source_select = source_t'(st.w_data[1:0]);
                  flag_clr = !st.w_data[MODE_FLAG_BIT];
               end
               IDX_COUNT:
               begin
                  nx.reload = st.w_data[UPPER_W-1:0];
                  nx.clr_strobe = st.w_data[CLEAR_BIT];
               end
               IDX_STATUS: stat_clr = st.w_data[0];
               IDX_MASK: nx.mask = st.w_data[0];
               default: nx.bresp = RESP_SLVERR;
            endcase
         end
      end
      nx.mode.irq_flag = evt || (st.mode.irq_flag && !flag_clr && !irq_ack);
      // Sticky status, write one to clear
      nx.status = evt || (st.status && !stat_clr);
      nx.irq = nx.status && nx.mask;
      // Read channel
      if (st.rvalid && rready)
      begin
         nx.rvalid = 1'b0;
      end
      if (st.arready && arvalid)
      begin
         nx.rvalid = 1'b1;
         nx.rdata = read_word(araddr[ADDR_W-1:2], st);
         nx.rresp = mapped(araddr[ADDR_W-1:2]) ? RESP_OKAY : RESP_SLVERR;
      end
      nx.awready = !nx.aw_have;
      nx.wready = !nx.w_have;
      nx.arready = !nx.rvalid;
   end

   // State register
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         st <= '0;
         st.mode <= MODE_RESET;
         st.reload <= RELOAD_RESET;
         st.mask <= MASK_RESET;
         st.awready <= 1'b1;
         st.wready <= 1'b1;
         st.arready <= 1'b1;
      end
      else
      begin
         st <= nx;
      end
   end

   // Outputs straight from the state register
   assign awready = st.awready;
   assign wready = st.wready;
   assign bvalid = st.bvalid;
   assign bresp = st.bresp;
   assign arready = st.arready;
   assign rvalid = st.rvalid;
   assign rdata = st.rdata;
   assign rresp = st.rresp;
   assign watch_irq_flag = st.mode.irq_flag;
   assign irq = st.irq;

   // Checks
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   // Counting step condition
   sequence s_counting;
      st.mode.run_en && !st.clr_strobe && tick;
   endsequence

   // Prescaler wrap condition
   sequence s_wrap;
      s_counting ##0 (&st.pre);
   endsequence

   // Count register read taken
   sequence s_read_count;
      st.arready && arvalid && (araddr[ADDR_W-1:2] == IDX_COUNT);
   endsequence

   AST_STOP_CLEARS: assert property (!st.mode.run_en |=> st.pre == '0 && st.upper == '0)
      else $error("counter not zero while disabled");
   AST_SUB_IN_STOP: assert property ((st.mode.source_select == SRC_SUB) && cpu_stop
                                     && sub_tick ##0 s_counting |=> st.pre == $past(st.pre) + 1'b1)
      else $error("sub clock count lost in stop");
   AST_MAIN_FROZEN: assert property ((st.mode.source_select != SRC_SUB) && cpu_stop
                                     && st.mode.run_en && !st.clr_strobe |=> $stable(st.pre))
      else $error("main source counted in stop");
   AST_UPPER_CARRY: assert property (s_wrap ##0 (st.upper < st.reload)
                                     |=> st.upper == $past(st.upper) + 1'b1 && st.pre == '0)
      else $error("upper section missed carry");
   AST_RELOAD_WRAP: assert property (s_wrap ##0 (st.upper >= st.reload) |=> st.upper == '0)
      else $error("upper section failed to reload");
   // shared write loads reload and clear
   AST_CLEAR_WRITE: assert property (do_write && st.w_strb[0] && w_idx == IDX_COUNT
                                     |=> st.reload == $past(st.w_data[6:0])
                                     && st.clr_strobe == $past(st.w_data[CLEAR_BIT]))
      else $error("shared write not applied");
   AST_STROBE_SELF: assert property (st.clr_strobe && !(do_write && w_idx == IDX_COUNT)
                                     |=> !st.clr_strobe && st.pre == '0 && st.upper == '0)
      else $error("clear strobe misbehaved");
   AST_COUNT_READ: assert property (s_read_count |=> st.rvalid
                                    && st.rdata == {25'h000_0000, $past(st.upper)})
      else $error("count readback wrong");
   AST_DIV64: assert property (main_osc_clock && !cpu_stop && st.mode.source_select == SRC_DIV64
                               && st.main_div[5:0] == 6'h3f |-> tick)
      else $error("main divide by 64 missed");
   AST_INT_2048: assert property (s_counting ##0 (st.mode.interval_select == INT_2048
                                  && &st.pre[SPAN_2048-1:0]) |-> evt)
      else $error("2048 interval event missed");
   AST_FLAG_SET: assert property (evt && st.mask && !(do_write && w_idx == IDX_MASK)
                                  |=> st.mode.irq_flag && st.status && st.irq)
      else $error("event did not raise interrupt");
   AST_ACK_CLEAR: assert property (irq_ack && !evt |=> !st.mode.irq_flag)
      else $error("acknowledge did not clear flag");

endmodule // watch_timer_rtc
`default_nettype wire

//--- bench/watch_timer_rtc_tb_top.sv
// Self-checking register-level testbench for the watch timer block
`timescale 1ns/1ns
`default_nettype none
module watch_timer_rtc_tb_top;
   import wt_pkg::*;
   // Design connections
   logic aclk, aresetn, sub_tick, main_osc_clock, cpu_stop, irq_ack, watch_irq_flag, irq;
   logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic [ADDR_W-1:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rdat;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, resp;
   int errors, check_count;
   // Byte addresses, four times the index
   localparam logic [ADDR_W-1:0] A_MODE = {IDX_MODE, 2'b00};
   localparam logic [ADDR_W-1:0] A_CNT = {IDX_COUNT, 2'b00};
   localparam logic [ADDR_W-1:0] A_STAT = {IDX_STATUS, 2'b00};
   localparam logic [ADDR_W-1:0] A_MASK = {IDX_MASK, 2'b00};
   localparam logic [ADDR_W-1:0] A_BAD = 12'h0ffc;

   watch_timer_rtc watch_timer_rtc_i (.aclk(aclk), .aresetn(aresetn), .sub_tick(sub_tick),
      .main_osc_clock(main_osc_clock), .cpu_stop(cpu_stop), .irq_ack(irq_ack), .watch_irq_flag(watch_irq_flag),
      .irq(irq), .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
      .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
      .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp));

   // Free-running 100 MHz clock
   initial
   begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   // Write one byte register; ready sampled at the negedge before the transfer edge
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
      logic ta, tw, da, dw;
      da = 1'b0;
      dw = 1'b0;
      awvalid <= 1'b1;
      awaddr <= a;
      wvalid <= 1'b1;
      wdata <= {24'h00_0000, d};
      wstrb <= 4'hf;
      bready <= 1'b1;
      while (!(da && dw))
      begin
         @(negedge aclk);
         ta = awready && !da;
         tw = wready && !dw;
         @(posedge aclk);
         da = da || ta;
         dw = dw || tw;
         if (ta)
            awvalid <= 1'b0;
         if (tw)
            wvalid <= 1'b0;
      end
      do
      begin
         @(negedge aclk);
         ta = bvalid;
         resp = bresp;
         @(posedge aclk);
      end while (!ta);
      // Response ready stays high, so back-to-back writes never toggle it in one step
   endtask

   // Read one register into rdat and resp
   task automatic rd(input logic [ADDR_W-1:0] a);
      logic t;
      arvalid <= 1'b1;
      araddr <= a;
      rready <= 1'b1;
      do
      begin
         @(negedge aclk);
         t = arready;
         @(posedge aclk);
      end while (!t);
      arvalid <= 1'b0;
      do
      begin
         @(negedge aclk);
         t = rvalid;
         rdat = rdata;
         resp = rresp;
         @(posedge aclk);
      end while (!t);
      // Read ready stays high, so back-to-back reads never toggle it in one step
   endtask

   // Value compare
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         errors++;
         $display("[ERR] %0t: value %h expected %h", $time, got, exp);
      end
   endtask

   // Flag and interrupt compare after the event has had time to land
   task automatic flag_is(input logic f, input logic i);
      repeat (3) @(posedge aclk);
      @(negedge aclk);
      check_count += 2;
      if (watch_irq_flag !== f || irq !== i)
      begin
         errors++;
         $display("[ERR] %0t: flag %b irq %b expected %b %b", $time, watch_irq_flag, irq, f, i);
      end
      @(posedge aclk);
   endtask

   // Exactly n sub clock enables
   task automatic tick(input int n);
      sub_tick <= 1'b1;
      repeat (n) @(posedge aclk);
      sub_tick <= 1'b0;
   endtask

   // Exactly n main oscillator enables
   task automatic main_pulse(input int n);
      main_osc_clock <= 1'b1;
      repeat (n) @(posedge aclk);
      main_osc_clock <= 1'b0;
   endtask

   // One-cycle acknowledge from the interrupt controller
   task automatic ack;
      irq_ack <= 1'b1;
      @(posedge aclk);
      irq_ack <= 1'b0;
   endtask

   // Verdict and end of run
   task end_sim;
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // Hang guard, about 15 percent beyond the expected run
   initial
   begin
      #900_000;
      errors++;
      end_sim;
   end

   // Main sequence
   initial
   begin
      {aresetn, sub_tick, main_osc_clock, cpu_stop, irq_ack, awvalid, wvalid, bready, arvalid, rready} = '0;
      awaddr = '0;
      araddr = '0;
      wdata = '0;
      wstrb = '0;
      errors = 0;
      check_count = 0;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      // Reset values and unmapped access
      rd(A_MODE); chk(rdat, 32'h0000_0000);
      rd(A_CNT); chk(rdat, 32'h0000_0000);
      rd(A_STAT); chk(rdat, 32'h0000_0000);
      rd(A_MASK); chk(rdat, 32'h0000_0000);
      rd(A_BAD); chk(32'(resp), 32'(RESP_SLVERR)); chk(rdat, 32'h0000_0000);
      // Unmapped write answers with an error
      wr(A_BAD, 8'h5a);
      chk(32'(resp), 32'(RESP_SLVERR));
      // Unused bits read zero, flag write of one ignored
      wr(A_MODE, 8'hff);
      chk(32'(resp), 32'(RESP_OKAY));
      rd(A_MODE); chk(rdat, 32'h0000_008f);
      wr(A_MODE, 8'h00);
      // Sub clock, interval 2048, then mask and status
      wr(A_MODE, 8'h80);
      tick(2040); flag_is(1'b0, 1'b0);
      tick(16); flag_is(1'b1, 1'b0);
      wr(A_MASK, 8'h01); flag_is(1'b1, 1'b1);
      wr(A_STAT, 8'h01); flag_is(1'b1, 1'b0);
      wr(A_MODE, 8'h80); flag_is(1'b0, 1'b0);
      // Clear strobe restarts the count
      tick(1000); wr(A_CNT, 8'hff);
      tick(2040); flag_is(1'b0, 1'b0);
      tick(16); flag_is(1'b1, 1'b1);
      ack; flag_is(1'b0, 1'b1);
      wr(A_STAT, 8'h01);
      // Disable zeroes the count; sub clock keeps running in stop mode
      tick(1000); wr(A_MODE, 8'h00); tick(200);
      cpu_stop <= 1'b1;
      wr(A_MODE, 8'h80);
      tick(2040); flag_is(1'b0, 1'b0);
      tick(16); flag_is(1'b1, 1'b1);
      ack;
      wr(A_STAT, 8'h01);
      cpu_stop <= 1'b0;
      // Longer fixed intervals
      for (int k = 1; k < 3; k++)
      begin
         wr(A_MODE, 8'h00);
         wr(A_MODE, 8'(8'h80 + 4 * k));
         tick((k == 1 ? 8192 : 16384) - 8); flag_is(1'b0, 1'b0);
         tick(16); flag_is(1'b1, 1'b1);
         ack;
         wr(A_STAT, 8'h01);
      end
      // Reload mode with value one: period 2^14 times two
      wr(A_MODE, 8'h00);
      wr(A_CNT, 8'h01); wr(A_MODE, 8'h8c);
      tick(16484); rd(A_CNT); chk(rdat, 32'h0000_0001);
      tick(16276); flag_is(1'b0, 1'b0);
      tick(16); flag_is(1'b1, 1'b1);
      rd(A_CNT); chk(rdat, 32'h0000_0000);
      ack;
      wr(A_STAT, 8'h01);
      // Each main divider adds 16 steps; stop mode freezes them
      wr(A_MODE, 8'h00);
      wr(A_MODE, 8'h83);
      main_pulse(1024);
      wr(A_MODE, 8'h82);
      main_pulse(2048);
      wr(A_MODE, 8'h81);
      main_pulse(4096);
      cpu_stop <= 1'b1;
      @(posedge aclk);
      main_pulse(1024);
      cpu_stop <= 1'b0;
      // Sub clock finishes the interval from 48 steps
      wr(A_MODE, 8'h80);
      tick(1992);
      flag_is(1'b0, 1'b0);
      tick(16);
      flag_is(1'b1, 1'b1);
      ack;
      wr(A_STAT, 8'h01);
      // Main clock source ignores sub enables
      wr(A_MODE, 8'h00);
      wr(A_MODE, 8'h83);
      tick(2100); flag_is(1'b0, 1'b0);
      end_sim;
   end
endmodule // watch_timer_rtc_tb_top
`default_nettype wire
